/* hdl/usd_cfg.svh */
// Purpose: constants of the serial status and data register block
// Assumes: 32-bit register words on the peripheral bus
// Notes:   offsets are byte addresses
`ifndef USD_CFG_SVH
`define USD_CFG_SVH

`define USD_DATA_W        9
`define USD_ADDR_W        8
`define USD_OFF_STATUS    8'h00
`define USD_OFF_DATA      8'h04
`define USD_OFF_CTRL      8'h0C

`define USD_BIT_PAR_ERR   0
`define USD_BIT_FRM_ERR   1
`define USD_BIT_NOISE     2
`define USD_BIT_OVERRUN   3
`define USD_BIT_IDLE      4
`define USD_BIT_RX_FULL   5
`define USD_BIT_TXEMPTY   7

`define USD_BIT_ODD       9
`define USD_BIT_PAR_EN    10
`define USD_BIT_NINE      12

`define USD_RST_CTRL      1'b0
`define USD_RST_DATA      9'h000
`define USD_RST_WORD      32'h0000_0000

`endif

/* hdl/usd_pkg.sv */
// Purpose: shared types of the serial status and data register block
// Assumes: usd_cfg.svh holds the numbers
// Notes:   types and one decode function only
`include "usd_cfg.svh"

package usd_pkg;

	typedef enum logic [1:0] {
		USD_BUS_IDLE,
		USD_BUS_WR,
		USD_BUS_RD_WAIT,
		USD_BUS_RD_DONE
	} usd_bus_state_t;

	function automatic logic usd_hit(
		input logic [`USD_ADDR_W-1:0] addr,
		input logic [`USD_ADDR_W-1:0] off
	);
		usd_hit = (addr == off);
	endfunction

endpackage

/* hdl/usd_parity.sv */
// Purpose: parity of a serial word below its top data bit
// Assumes: top bit sits at W-1 for long words and W-2 for short ones
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none

module usd_parity #(
	parameter int W = 9
) (
	input  wire logic [W-1:0] word,
	input  wire logic         full_len,
	input  wire logic         odd,
	output logic              par
);
	generate
		if (W < 3) begin : g_bad_width
			$error("usd_parity: width below 3 not served");
		end
	endgenerate

	wire logic [W-1:0] mask_long;
	wire logic [W-1:0] mask_short;
	wire logic [W-1:0] mask;

	assign mask_long  = {1'b0, {(W-1){1'b1}}};
	assign mask_short = {2'b00, {(W-2){1'b1}}};
	assign mask       = full_len ? mask_long : mask_short;
	// even parity makes the total count even; odd flips it
	assign par        = (^(word & mask)) ^ odd;
endmodule // usd_parity

`default_nettype wire

/* hdl/usd_ahb_slave.sv */
// Purpose: AHB-Lite slave front end for the register block
// Assumes: single word transfers, one slave on the bus
// Notes:   writes take no wait; reads take one wait state
`timescale 1ns/1ps
`default_nettype none
`include "usd_cfg.svh"

module usd_ahb_slave
	import usd_pkg::*;
#(
	parameter int ADDR_W = `USD_ADDR_W
) (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic                   wr_stb,
	output logic                   rd_stb,
	output logic [ADDR_W-1:0]      reg_addr
);
	generate
		if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
			$error("usd_ahb_slave: address width out of range");
		end
	endgenerate

	usd_bus_state_t    state_reg;
	usd_bus_state_t    state_next;
	logic [ADDR_W-1:0] addr_reg;

	wire logic accept;

	// the wait state lets the registered read data be loaded on rd_stb before it is taken
	assign accept = hsel & htrans[1] & hready;

	always_comb begin
		case (state_reg)
			USD_BUS_RD_WAIT: state_next = USD_BUS_RD_DONE;
			default: begin
				if (accept) begin
					state_next = hwrite ? USD_BUS_WR : USD_BUS_RD_WAIT;
				end else begin
					state_next = USD_BUS_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= USD_BUS_IDLE;
			addr_reg  <= '0;
		end else begin
			state_reg <= state_next;
			if (accept) begin
				addr_reg <= haddr[ADDR_W-1:0];
			end
		end
	end

	assign hreadyout = (state_reg != USD_BUS_RD_WAIT);
	assign hresp     = 1'b0;
	assign wr_stb    = (state_reg == USD_BUS_WR);
	assign rd_stb    = (state_reg == USD_BUS_RD_WAIT);
	assign reg_addr  = addr_reg;
endmodule // usd_ahb_slave

`default_nettype wire

/* hdl/usd_top.sv */
// Purpose: status flags and data word of a serial transceiver
// Assumes: shift logic delivers whole words with their error marks
// Notes:   one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
`include "usd_cfg.svh"

module usd_top
	import usd_pkg::*;
#(
	parameter int DATA_W = `USD_DATA_W,
	parameter int ADDR_W = `USD_ADDR_W
) (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	input  wire logic              rx_load,
	input  wire logic [DATA_W-1:0] rx_word,
	input  wire logic              rx_noise,
	input  wire logic              rx_frame_err,
	input  wire logic              rx_break,
	input  wire logic              rx_idle,
	output logic                   tx_valid,
	input  wire logic              tx_ready,
	output logic [DATA_W-1:0]      tx_word,
	output logic                   parity_enable,
	output logic                   parity_odd,
	output logic                   word_nine
);
	generate
		if (DATA_W != 9) begin : g_bad_data
			$error("usd_top: only a 9-bit data word is served");
		end
		// the shared decode function is fixed at this width
		if (ADDR_W != `USD_ADDR_W) begin : g_bad_addr
			$error("usd_top: register decode needs the default width");
		end
	endgenerate

	// bus front end
	logic              wr_stb;
	logic              rd_stb;
	logic [ADDR_W-1:0] reg_addr;

	usd_ahb_slave #(
		.ADDR_W    (ADDR_W)
	) u_bus (
		.clock     (clock),
		.rst       (rst),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.wr_stb    (wr_stb),
		.rd_stb    (rd_stb),
		.reg_addr  (reg_addr)
	);

	// hsize is not checked: only whole words are ever issued
	wire logic [2:0] size_unused;
	assign size_unused = hsize;

	// decode
	wire logic sel_sts;
	wire logic sel_data;
	wire logic sel_ctrl;

	assign sel_sts  = usd_hit(reg_addr, `USD_OFF_STATUS);
	assign sel_data = usd_hit(reg_addr, `USD_OFF_DATA);
	assign sel_ctrl = usd_hit(reg_addr, `USD_OFF_CTRL);

	wire logic sts_read;
	wire logic data_read;
	wire logic data_write;
	wire logic ctrl_write;
	wire logic sts_write;

	assign sts_read   = rd_stb & sel_sts;
	assign data_read  = rd_stb & sel_data;
	assign data_write = wr_stb & sel_data;
	assign ctrl_write = wr_stb & sel_ctrl;
	assign sts_write  = wr_stb & sel_sts;

	// control bits
	logic par_en_reg;
	logic odd_reg;
	logic nine_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			par_en_reg <= `USD_RST_CTRL;
			odd_reg    <= `USD_RST_CTRL;
			nine_reg   <= `USD_RST_CTRL;
		end else if (ctrl_write) begin
			par_en_reg <= hwdata[`USD_BIT_PAR_EN];
			odd_reg    <= hwdata[`USD_BIT_ODD];
			nine_reg   <= hwdata[`USD_BIT_NINE];
		end
	end

	assign parity_enable = par_en_reg;
	assign parity_odd    = odd_reg;
	assign word_nine     = nine_reg;

	// parity on both paths
	wire logic [DATA_W-1:0] tx_src;
	wire logic              tx_par;
	wire logic              rx_par;
	wire logic              rx_par_got;
	wire logic              rx_par_bad;

	assign tx_src = hwdata[DATA_W-1:0];

	usd_parity #(
		.W        (DATA_W)
	) u_tx_par (
		.word     (tx_src),
		.full_len (nine_reg),
		.odd      (odd_reg),
		.par      (tx_par)
	);

	usd_parity #(
		.W        (DATA_W)
	) u_rx_par (
		.word     (rx_word),
		.full_len (nine_reg),
		.odd      (odd_reg),
		.par      (rx_par)
	);

	assign rx_par_got = nine_reg ? rx_word[DATA_W-1] : rx_word[DATA_W-2];
	assign rx_par_bad = par_en_reg & (rx_par_got != rx_par);

	// top written bit swapped for the computed parity
	wire logic [DATA_W-1:0] tx_long;
	wire logic [DATA_W-1:0] tx_short;
	wire logic [DATA_W-1:0] tx_fill;

	assign tx_long  = {tx_par, tx_src[DATA_W-2:0]};
	assign tx_short = {tx_src[DATA_W-1], tx_par, tx_src[DATA_W-3:0]};
	assign tx_fill  = !par_en_reg ? tx_src
	                : (nine_reg ? tx_long : tx_short);

	// transmit hand-off, single word: a new write replaces an untaken one
	logic [DATA_W-1:0] tx_word_reg;
	logic              tx_valid_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			tx_word_reg  <= `USD_RST_DATA;
			tx_valid_reg <= 1'b0;
		end else begin
			if (data_write) begin
				tx_word_reg <= tx_fill;
			end
			tx_valid_reg <= data_write | (tx_valid_reg & ~tx_ready);
		end
	end

	assign tx_valid = tx_valid_reg;
	assign tx_word  = tx_word_reg;

	// receive side flags
	logic              rxfull_reg;
	logic              idle_reg;
	logic              seen_reg;
	logic [3:0]        err_reg;
	logic [DATA_W-1:0] data_reg;

	wire logic take_word;
	wire logic ovr_event;
	wire logic seq_clear;
	wire logic rxfull_clear;

	// a word completing while the buffer is full is dropped, not stored
	assign take_word    = rx_load & ~rxfull_reg;
	assign ovr_event    = rx_load & rxfull_reg;
	assign seq_clear    = data_read & seen_reg;
	// writing 1 to the full bit leaves it alone
	assign rxfull_clear = data_read
	                    | (sts_write & ~hwdata[`USD_BIT_RX_FULL]);

	wire logic rxfull_next;
	wire logic idle_next;
	wire logic seen_next;

	// set wins over clear on every flag
	assign rxfull_next = (rxfull_reg & ~rxfull_clear)
	                   | rx_load;
	assign idle_next   = (idle_reg & ~seq_clear) | rx_idle;
	// any data read ends the sequence
	assign seen_next   = sts_read | (seen_reg & ~data_read);

	always_ff @(posedge clock) begin
		if (rst) begin
			rxfull_reg <= 1'b0;
			idle_reg   <= 1'b0;
			seen_reg   <= 1'b0;
		end else begin
			rxfull_reg <= rxfull_next;
			idle_reg   <= idle_next;
			seen_reg   <= seen_next;
		end
	end

	// error flags, indexed by their status bit; one shared clear
	wire logic [3:0] err_set;
	wire logic [3:0] err_next;

	// errors of a dropped word are not kept: only the overrun shows, plus framing if rx_break is set
	assign err_set[`USD_BIT_PAR_ERR] = take_word
	                                 & rx_par_bad;
	assign err_set[`USD_BIT_FRM_ERR] = (take_word & rx_frame_err)
	                                 | rx_break;
	assign err_set[`USD_BIT_NOISE]   = take_word
	                                 & rx_noise;
	assign err_set[`USD_BIT_OVERRUN] = ovr_event;

	generate
		for (genvar gi = 0; gi < 4; gi++) begin : g_err
			assign err_next[gi] = (err_reg[gi] & ~seq_clear)
			                    | err_set[gi];
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (rst) begin
			err_reg <= 4'h0;
		end else begin
			err_reg <= err_next;
		end
	end

	// the raw word keeps the received parity bit in its top position
	always_ff @(posedge clock) begin
		if (rst) begin
			data_reg <= `USD_RST_DATA;
		end else if (take_word) begin
			data_reg <= rx_word;
		end
	end

	// read data
	wire logic [31:0] sts_value;
	wire logic [31:0] data_value;
	wire logic [31:0] ctrl_value;
	wire logic [31:0] rd_value;

	assign sts_value  = {24'h00_0000,
	                     ~tx_valid_reg, // tx empty
	                     1'b0,
	                     rxfull_reg,
	                     idle_reg,
	                     err_reg};
	assign data_value = {{(32-DATA_W){1'b0}}, data_reg};
	assign ctrl_value = {19'h0_0000,
	                     nine_reg,
	                     1'b0,
	                     par_en_reg,
	                     odd_reg,
	                     9'h000};
	assign rd_value   = sel_sts  ? sts_value
	                  : sel_data ? data_value
	                  : sel_ctrl ? ctrl_value
	                  : `USD_RST_WORD;

	logic [31:0] hrdata_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			hrdata_reg <= `USD_RST_WORD;
		end else if (rd_stb) begin
			hrdata_reg <= rd_value;
		end
	end

	assign hrdata = hrdata_reg;
endmodule // usd_top

`default_nettype wire

/* verif/usd_top_asserts.sv */
// Purpose: bus and transmit checks of the register block
// Assumes: hready tied to hreadyout
// Notes:   flags are judged by the bench through reads
`timescale 1ns/1ps
`default_nettype none

module usd_top_asserts #(
	parameter int DATA_W = 9
) (
	input wire logic              clock,
	input wire logic              rst,
	input wire logic              hsel,
	input wire logic [31:0]       haddr,
	input wire logic [1:0]        htrans,
	input wire logic              hwrite,
	input wire logic              hready,
	input wire logic              hreadyout,
	input wire logic              hresp,
	input wire logic [31:0]       hrdata,
	input wire logic              tx_valid,
	input wire logic              tx_ready,
	input wire logic [DATA_W-1:0] tx_word,
	input wire logic              parity_enable,
	input wire logic              parity_odd,
	input wire logic              word_nine
);
	wire logic take = hsel & htrans[1] & hready;
	wire logic dat = (haddr[7:0] == 8'h04);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	a_tx_launch: assert property (take && hwrite && dat |-> ##2 tx_valid)
		else $error("data write did not launch");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid)
		else $error("word dropped before take");
	a_tx_release: assert property ($fell(tx_valid) |-> $past(tx_ready))
		else $error("word left without take");
	a_tx_parity: assert property ($rose(tx_valid) && parity_enable |->
		(word_nine ? tx_word[8] == (^tx_word[7:0] ^ parity_odd)
		: tx_word[7] == (^tx_word[6:0] ^ parity_odd)))
		else $error("sent parity bit wrong");
	a_data_upper: assert property (take && !hwrite && dat |-> ##2 hrdata[31:9] == '0)
		else $error("data upper bits not zero");
endmodule // usd_top_asserts
`default_nettype wire

/* verif/usd_link_model.sv */
// Purpose: shift logic stand-in on both serial sides
// Assumes: one clock shared with the block
// Notes:   stall sets how long a sent word waits
`timescale 1ns/1ps
`default_nettype none

module usd_link_model (
	input  wire logic       clock,
	input  wire logic [3:0] stall,
	input  wire logic       tx_valid,
	input  wire logic [8:0] tx_word,
	output logic            tx_ready,
	output logic            rx_load,
	output logic [8:0]      rx_word,
	output logic            rx_noise,
	output logic            rx_frame_err,
	output logic            rx_break,
	output logic            rx_idle
);
	int         waited;
	int         takes;
	logic [8:0] last_tx;

	initial begin
		{tx_ready, rx_load, rx_noise, rx_frame_err, rx_break, rx_idle} = '0;
		rx_word = 9'h000;
		takes = 0;
		waited = 0;
	end
	// a busy shifter holds off ready, so the word must stand
	always @(posedge clock) begin
		if (tx_valid && tx_ready) begin
			last_tx <= tx_word;
			takes <= takes + 1;
			tx_ready <= 1'b0;
			waited <= 0;
		end else if (tx_valid) begin
			waited <= waited + 1;
			tx_ready <= (waited >= int'(stall));
		end
	end
	// flags f: idle, break, framing, noise; an edge passes before the next
	task automatic send(input logic [8:0] w, input logic ld, input logic [3:0] f);
		rx_word <= w;
		rx_load <= ld;
		{rx_idle, rx_break, rx_frame_err, rx_noise} <= f;
		@(posedge clock);
		rx_load <= 1'b0;
		{rx_idle, rx_break, rx_frame_err, rx_noise} <= 4'h0;
		rx_word <= ~w;
		@(posedge clock);
	endtask
endmodule // usd_link_model
`default_nettype wire

/* verif/tb_top.sv */
// Purpose: self-checking bench of the register block
// Assumes: link model plays the shift logic
// Notes:   rows cover every parity mode
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	typedef struct packed {
		logic [15:0] ctrl;
		logic [31:0] wr;
		logic [8:0]  tx;
		logic [8:0]  rx;
		logic        nz;
		logic        fe;
		logic [7:0]  st;
		logic [8:0]  rdv;
	} usd_row_t;
	usd_row_t rows [5] = '{
		'{16'h1000, 32'hFFFF_FFA5, 9'h1A5, 9'h0C3, 1'b1, 1'b0, 8'hA4, 9'h0C3},
		'{16'h1400, 32'h0000_01FF, 9'h0FF, 9'h103, 1'b0, 1'b0, 8'hA1, 9'h103},
		'{16'h1600, 32'h0000_0001, 9'h001, 9'h001, 1'b0, 1'b1, 8'hA2, 9'h001},
		'{16'h0400, 32'h0000_0083, 9'h003, 9'h081, 1'b0, 1'b0, 8'hA0, 9'h081},
		'{16'h0600, 32'h0000_0007, 9'h007, 9'h087, 1'b0, 1'b0, 8'hA1, 9'h087}};
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [3:0]  stall = 4'h0;
	logic [31:0] rd;
	int          fail_count = 0;
	int          checked = 0;
	int          t0;
	wire logic   hreadyout, hresp, tx_valid, tx_ready, rx_load;
	wire logic   rx_noise, rx_frame_err, rx_break, rx_idle;
	wire logic   parity_enable, parity_odd, word_nine;
	wire logic [3:0]  ctl_out = {word_nine, 1'b0, parity_enable, parity_odd};
	wire logic [31:0] hrdata;
	wire logic [8:0]  rx_word, tx_word;

	usd_top uut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .rx_load(rx_load), .rx_word(rx_word),
		.rx_noise(rx_noise), .rx_frame_err(rx_frame_err),
		.rx_break(rx_break), .rx_idle(rx_idle), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_word(tx_word),
		.parity_enable(parity_enable), .parity_odd(parity_odd),
		.word_nine(word_nine));
	usd_link_model link (.clock(clock), .stall(stall), .tx_valid(tx_valid),
		.tx_word(tx_word), .tx_ready(tx_ready), .rx_load(rx_load),
		.rx_word(rx_word), .rx_noise(rx_noise), .rx_frame_err(rx_frame_err),
		.rx_break(rx_break), .rx_idle(rx_idle));

	always #2 clock = ~clock;

	task automatic tally_and_finish;
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// bounded waits: a hang counts as a mismatch
	task automatic give_up(input int n);
		if (n > 40) begin
			fail_count++;
			tally_and_finish();
		end
	endtask
	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge clock);
		while (hreadyout !== 1'b1) begin
			n++;
			give_up(n);
			@(posedge clock);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		wait_ready();
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		check(rd, e);
	endtask
	task automatic tx_chk(input logic [8:0] e);
		int n;
		n = 0;
		while (link.takes == t0) begin
			n++;
			give_up(n);
			@(posedge clock);
		end
		check(32'(link.last_tx), 32'(e));
	endtask

	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			stall <= i[0] ? 4'h3 : 4'h0;
			bus(1'b1, 8'h0C, 32'(rows[i].ctrl));
			rd_chk(8'h0C, 32'(rows[i].ctrl));
			check(32'(ctl_out), 32'(rows[i].ctrl[12:9]));
			t0 = link.takes;
			bus(1'b1, 8'h04, rows[i].wr);
			tx_chk(rows[i].tx);
			link.send(rows[i].rx, 1'b1, {2'b00, rows[i].fe, rows[i].nz});
			rd_chk(8'h00, 32'(rows[i].st));
			rd_chk(8'h04, 32'(rows[i].rdv));
			rd_chk(8'h00, 32'h0000_0080);
		end
		bus(1'b1, 8'h0C, 32'h0000_1000);
		link.send(9'h055, 1'b1, 4'h0);
		link.send(9'h0AA, 1'b1, 4'h1);
		rd_chk(8'h00, 32'h0000_00A8);
		rd_chk(8'h04, 32'h0000_0055);
		rd_chk(8'h00, 32'h0000_0080);
		link.send(9'h000, 1'b0, 4'h8);
		rd_chk(8'h00, 32'h0000_0090);
		bus(1'b1, 8'h00, 32'h0000_0000);
		rd_chk(8'h00, 32'h0000_0090);
		rd_chk(8'h04, 32'h0000_0055);
		rd_chk(8'h00, 32'h0000_0080);
		link.send(9'h1C3, 1'b1, 4'h0);
		bus(1'b1, 8'h00, 32'hFFFF_FFFF);
		rd_chk(8'h00, 32'h0000_00A0);
		bus(1'b1, 8'h00, 32'h0000_0000);
		rd_chk(8'h00, 32'h0000_0080);
		link.send(9'h000, 1'b0, 4'h4);
		rd_chk(8'h00, 32'h0000_0082);
		rd_chk(8'h04, 32'h0000_01C3);
		rd_chk(8'h00, 32'h0000_0080);
		bus(1'b1, 8'h08, 32'hFFFF_FFFF);
		rd_chk(8'h08, 32'h0000_0000);
		link.send(9'h155, 1'b1, 4'h3);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rd_chk(8'h00, 32'h0000_0080);
		rd_chk(8'h04, 32'h0000_0000);
		tally_and_finish();
	end
endmodule // tb_top

bind usd_top usd_top_asserts #(.DATA_W(DATA_W)) chk (.clock(clock), .rst(rst),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word),
	.parity_enable(parity_enable), .parity_odd(parity_odd),
	.word_nine(word_nine));
`default_nettype wire
